//--- spg_top.sv
// Functional notes
// RULE1: eight independent step and direction outputs, all running concurrently.
// RULE2: host supplies eight velocity words per update, 12-bit velocity field each.
// RULE3: raise an update request to the host 107 times per second.
// RULE4: host writes the next eight velocity words after every request.
// RULE5: velocity field values up to 255 set the speed directly.
// RULE6: step rate equals velocity times 107 Hz.
// RULE7: velocities above 255 clamp to 255, the maximum rate.
// RULE8: word top bit gives direction: zero forward, one reverse.
// RULE9: step output idles high and pulses low once per motor step.
// RULE10: direction output high for forward, low for reverse.
// RULE11: zero velocity produces no steps; step output stays idle.
module spg_top
  import spg_pkg::*;
#(
  parameter int UPD_CYCLES = UPDATE_CYCLES
) (
  input wire logic clock_i,                  // system clock, 125 MHz
  input wire logic rst_n_i,                  // async reset, active low
  input wire logic vel_we_i,                 // velocity word write strobe
  input wire logic [CH_IDX_W-1:0] vel_chan_i, // channel addressed by the write
  input wire logic [WORD_W-1:0] vel_data_i,  // velocity word: dir bit 15, field 11:0
  output logic [NUM_CH-1:0] step_n_o,        // step pulses, idle high
  output logic [NUM_CH-1:0] dir_o,           // direction, high = forward
  output logic irq_o,                        // update request to the host
  output logic update_tick_o,                // pulse when a new set takes effect
  output logic sync_fault_o                  // pulse: set applied incomplete
);

  // ****************************************************************
  // update period timer
  // ****************************************************************
  logic [ACC_W-1:0] tick_cnt;
  logic [ACC_W-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    if (tick_cnt == ACC_W'(UPD_CYCLES - 1)) begin // RULE3
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_tick_cnt = tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // ****************************************************************
  // shadow set written by the host
  // ****************************************************************
  // words land in a shadow set so all eight channels switch together on
  // the tick; a half-written set never reaches the motors mid-period
  logic [SPEED_W-1:0] shadow_speed [NUM_CH];
  logic [SPEED_W-1:0] next_shadow_speed [NUM_CH];
  logic [NUM_CH-1:0] shadow_dir;
  logic [NUM_CH-1:0] next_shadow_dir;
  logic [NUM_CH-1:0] written;
  logic [NUM_CH-1:0] next_written;

  always_comb begin
    next_shadow_speed = shadow_speed;
    next_shadow_dir = shadow_dir;
    next_written = written;
    if (tick) begin
      next_written = MASK_RESET;
    end
    // a write in the tick cycle belongs to the new period and is kept
    if (vel_we_i) begin // RULE2 RULE4
      next_shadow_speed[vel_chan_i] = spg_clamp(vel_data_i); // RULE5 RULE7
      next_shadow_dir[vel_chan_i] = spg_dir_level(vel_data_i); // RULE8
      next_written[vel_chan_i] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        shadow_speed[i] <= SPEED_RESET;
      end
      shadow_dir <= '1;
      written <= MASK_RESET;
    end else begin
      shadow_speed <= next_shadow_speed;
      shadow_dir <= next_shadow_dir;
      written <= next_written;
    end
  end

  // ****************************************************************
  // active set, request and fault
  // ****************************************************************
  logic [SPEED_W-1:0] speed [NUM_CH];
  logic [SPEED_W-1:0] next_speed [NUM_CH];
  logic [NUM_CH-1:0] dir;
  logic [NUM_CH-1:0] next_dir;
  logic irq;
  logic next_irq;
  logic fault;
  logic next_fault;
  logic upd;

  always_comb begin
    next_speed = speed;
    next_dir = dir;
    next_irq = irq;
    next_fault = 1'b0;
    // a channel the host skipped keeps its last speed; zero stops it
    if (tick) begin
      next_speed = shadow_speed; // RULE11
      next_dir = shadow_dir; // RULE10
      next_fault = (written != ALL_WRITTEN);
    end
    if (vel_we_i && vel_chan_i == LAST_CH) begin
      next_irq = 1'b0;
    end
    // the request set wins over a clear in the same cycle
    if (tick) begin
      next_irq = 1'b1; // RULE3
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        speed[i] <= SPEED_RESET;
      end
      dir <= '1;
      irq <= 1'b0;
      fault <= 1'b0;
      upd <= 1'b0;
    end else begin
      speed <= next_speed;
      dir <= next_dir;
      irq <= next_irq;
      fault <= next_fault;
      upd <= tick;
    end
  end

  // ****************************************************************
  // step channels
  // ****************************************************************
  // every channel owns its accumulator, so all eight step concurrently
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan // RULE1
    spg_chan #(
      .PERIOD(UPD_CYCLES)
    ) u_chan (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .speed_i(speed[ch]),
      .step_n_o(step_n_o[ch])
    );
  end

  assign dir_o = dir;
  assign irq_o = irq;
  assign sync_fault_o = fault;
  assign update_tick_o = upd;
endmodule : spg_top

//--- spg_chan.sv
// ****************************************************************
// shared constants
// ****************************************************************
package spg_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_IDX_W = 3;
  localparam int WORD_W = 16;
  localparam int VEL_FIELD_W = 12;
  localparam int SPEED_W = 8;
  localparam logic [SPEED_W-1:0] SPEED_MAX = 8'hFF;
  localparam int DIR_BIT = 15;
  localparam logic [CH_IDX_W-1:0] LAST_CH = 3'h7;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int UPDATE_HZ = 107;
  // longest period rounds down to whole cycles
  localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
  localparam int ACC_W = 22;
  localparam int STEP_LOW_NS = 2000;
  // least low time rounds up to whole cycles
  localparam int STEP_LOW_CYCLES = (STEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_CNT_W = 8;
  localparam logic [NUM_CH-1:0] ALL_WRITTEN = 8'hFF;
  localparam logic [NUM_CH-1:0] MASK_RESET = 8'h00;
  localparam logic [SPEED_W-1:0] SPEED_RESET = 8'h00;

  // clamp the velocity field of a host word to the usable speed range
  function automatic logic [SPEED_W-1:0] spg_clamp(input logic [WORD_W-1:0] word);
    logic [VEL_FIELD_W-1:0] field;
    field = word[VEL_FIELD_W-1:0];
    if (field > VEL_FIELD_W'(SPEED_MAX)) begin
      spg_clamp = SPEED_MAX;
    end else begin
      spg_clamp = field[SPEED_W-1:0];
    end
  endfunction : spg_clamp

  // forward is a high direction level, so the word's top bit is inverted
  function automatic logic spg_dir_level(input logic [WORD_W-1:0] word);
    spg_dir_level = ~word[DIR_BIT];
  endfunction : spg_dir_level
endpackage : spg_pkg

// ****************************************************************
// one step channel: fractional rate accumulator and pulse shaper
// ****************************************************************
module spg_chan
  import spg_pkg::*;
#(
  parameter int PERIOD = UPDATE_CYCLES
) (
  input wire logic clock_i,               // system clock
  input wire logic rst_n_i,               // async reset, active low
  input wire logic [SPEED_W-1:0] speed_i, // steps per update period
  output logic step_n_o                   // step, idles high
);
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [LOW_CNT_W-1:0] low_cnt;
  logic [LOW_CNT_W-1:0] next_low_cnt;
  logic step_n;
  logic next_step_n;
  logic [ACC_W-1:0] sum;

  // adding speed each cycle and wrapping at PERIOD yields speed pulses
  // per PERIOD, i.e. speed times the update rate, with even spacing
  always_comb begin
    sum = acc + ACC_W'(speed_i);
    next_acc = sum;
    next_low_cnt = low_cnt;
    next_step_n = step_n;
    if (sum >= ACC_W'(PERIOD)) begin // RULE6
      next_acc = sum - ACC_W'(PERIOD);
      next_step_n = 1'b0; // RULE9
      next_low_cnt = LOW_CNT_W'(STEP_LOW_CYCLES - 1);
    end else if (!step_n) begin
      if (low_cnt == '0) begin
        next_step_n = 1'b1; // RULE9
      end else begin
        next_low_cnt = low_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= '0;
      low_cnt <= '0;
      step_n <= 1'b1;
    end else begin
      acc <= next_acc;
      low_cnt <= next_low_cnt;
      step_n <= next_step_n;
    end
  end

  assign step_n_o = step_n;
endmodule : spg_chan

//--- spg_top_chk.sv
// ****
// port checker of the step generator
// ****
module spg_chk
  import spg_pkg::*;
#(parameter int UPD_CYCLES = UPDATE_CYCLES) (
  input wire logic clock_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic vel_we_i, // write strobe
  input wire logic [CH_IDX_W-1:0] vel_chan_i, // write channel
  input wire logic [WORD_W-1:0] vel_data_i, // write word
  input wire logic [NUM_CH-1:0] step_n_o, // steps
  input wire logic [NUM_CH-1:0] dir_o, // directions
  input wire logic irq_o, // request
  input wire logic update_tick_o, // set applied
  input wire logic sync_fault_o // set incomplete
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  logic seen;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // the first period after reset has no earlier tick to measure from
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 0;
      seen <= 1'b0;
    end else begin
      gap <= update_tick_o ? 0 : gap + 1;
      seen <= seen | update_tick_o;
    end
  end
  a_irq_on_tick: assert property (update_tick_o |-> irq_o)
    else $error("request missing at tick");
  a_tick_period: assert property (update_tick_o && seen |-> gap == UPD_CYCLES - 1)
    else $error("tick spacing wrong");
  a_irq_clear: assert property (vel_we_i && vel_chan_i == LAST_CH |=> !irq_o || update_tick_o)
    else $error("request not cleared");
  a_irq_hold: assert property (irq_o && !(vel_we_i && vel_chan_i == LAST_CH) |=> irq_o)
    else $error("request dropped early");
  a_dir_hold: assert property (!update_tick_o |-> $stable(dir_o))
    else $error("direction moved between ticks");
  a_step_width: assert property ($fell(step_n_o[0]) |-> ##249 !step_n_o[0] ##1 step_n_o[0])
    else $error("step low time wrong");
  a_fault_tick: assert property (sync_fault_o |-> update_tick_o)
    else $error("fault outside tick");
  a_reset_idle: assert property ($rose(rst_n_i) |-> &step_n_o && &dir_o && !irq_o)
    else $error("outputs not idle after reset");
endmodule : spg_chk

bind spg_top spg_chk #(.UPD_CYCLES(UPD_CYCLES)) i_chk (.clock_i, .rst_n_i, .vel_we_i,
  .vel_chan_i, .vel_data_i, .step_n_o, .dir_o, .irq_o, .update_tick_o, .sync_fault_o);

//--- spg_host.sv
// ****
// host driver model: answers each request with eight words
// ****
module spg_host
  import spg_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic irq_i, // update request
  input wire logic en_i, // answer requests
  input wire logic [NUM_CH*WORD_W-1:0] words_i, // next set, channel 0 lowest
  output logic vel_we_o, // write strobe
  output logic [CH_IDX_W-1:0] vel_chan_o, // channel
  output logic [WORD_W-1:0] vel_data_o // word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [CH_IDX_W-1:0] idx;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      idx <= '0;
      vel_we_o <= 1'b0;
      vel_chan_o <= '0;
      vel_data_o <= '0;
    end else if (busy) begin
      vel_we_o <= 1'b1;
      vel_chan_o <= idx;
      vel_data_o <= words_i[idx*WORD_W +: WORD_W];
      idx <= idx + 3'h1;
      busy <= idx != LAST_CH;
    end else begin
      vel_we_o <= 1'b0;
      // idle data toggles so no stale word looks valid
      vel_data_o <= ~vel_data_o;
      idx <= '0;
      busy <= irq_i && !vel_we_o && en_i;
    end
  end
endmodule : spg_host

//--- eight_channel_step_pulse_generator_tb.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module eight_channel_step_pulse_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spg_pkg::*;
  localparam int UPD = 2000;
  localparam logic [15:0] BASE [8] = '{16'h0006, 16'h00FF, 16'h0FFF, 16'h0100, 16'h7F00,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] MSK [8] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
    16'hFFFF, 16'hF000, 16'hFFFF};
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b0;
  logic [NUM_CH*WORD_W-1:0] words = '0;
  logic [NUM_CH*WORD_W-1:0] wprev = '0;
  logic [NUM_CH-1:0] prev = 8'hFF;
  logic fault_seen;
  logic vel_we_i;
  logic [CH_IDX_W-1:0] vel_chan_i;
  logic [WORD_W-1:0] vel_data_i;
  logic [NUM_CH-1:0] step_n_o;
  logic [NUM_CH-1:0] dir_o;
  logic irq_o;
  logic update_tick_o;
  logic sync_fault_o;
  int err_total = 0;
  int compares = 0;
  int seed = 32'h4b71;
  int falls [NUM_CH] = '{default: 0};
  int win [NUM_CH];
  spg_top #(.UPD_CYCLES(UPD)) i_dut (.clock_i, .rst_n_i, .vel_we_i, .vel_chan_i,
    .vel_data_i, .step_n_o, .dir_o, .irq_o, .update_tick_o, .sync_fault_o);
  spg_host i_host (.clock_i, .rst_n_i, .irq_i(irq_o), .en_i(en), .words_i(words),
    .vel_we_o(vel_we_i), .vel_chan_o(vel_chan_i), .vel_data_o(vel_data_i));
  always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;
  // falls are counted per tick window; windows are one period long
  // sampled on the falling edge, where the registered outputs have settled
  always @(negedge clock_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      falls[c] += int'(prev[c] && !step_n_o[c]);
      if (update_tick_o) begin
        win[c] = falls[c];
        falls[c] = 0;
      end
    end
    if (update_tick_o) fault_seen = sync_fault_o;
    prev = step_n_o;
    `CHK(step_n_o[4:2], {3{step_n_o[1]}})
  end
  function automatic logic [NUM_CH-1:0] exp_dir(input logic [NUM_CH*WORD_W-1:0] w);
    for (int c = 0; c < NUM_CH; c++) exp_dir[c] = ~w[c*WORD_W+WORD_W-1];
  endfunction : exp_dir
  task summarize;
    $display("compares %0d, err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    repeat (UPD * 20) @(posedge clock_i);
    err_total++;
    summarize;
  end
  initial begin : main
    logic [NUM_CH*WORD_W-1:0] wn;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    en <= 1'b1;
    @(posedge clock_i);
    #1;
    `CHK(step_n_o, 8'hFF)
    `CHK(dir_o, 8'hFF)
    `CHK(irq_o, 1'b0)
    `CHK(sync_fault_o, 1'b0)
    for (int r = 0; r < 14; r++) begin
      @(posedge clock_i iff update_tick_o === 1'b1);
      for (int c = 0; c < NUM_CH; c++) wn[c*WORD_W +: WORD_W] = BASE[c] | (16'($random(seed)) & MSK[c]);
      words <= wn;
      // the host samples the enable at this same edge, so round 11 is still answered
      if (r == 11) en <= 1'b0;
      #1;
      `CHK(dir_o, exp_dir(wprev))
      `CHK(fault_seen, 1'(r == 0 || r == 13))
      if (r > 2) `CHK(win[0], 6)
      `CHK(win[6], 0)
      if (r == 13) `CHK(irq_o, 1'b1)
      if (r < 12) wprev = wn;
      $display("round %0d done", r);
    end
    summarize;
  end
endmodule : eight_channel_step_pulse_generator_tb
